// ### cpfs_regs.svh
`ifndef CPFS_REGS_SVH
`define CPFS_REGS_SVH

// Register addresses inside a page
`define CPFS_ADDR_PAGE_SEL 8'h00
`define CPFS_ADDR_DEV_CTRL2 8'h03
`define CPFS_ADDR_DROP_CTRL1 8'h04
`define CPFS_ADDR_DROP_CTRL2 8'h05
`define CPFS_ADDR_FAULT_STAT 8'h71
`define CPFS_ADDR_CLK_STAT 8'h72
`define CPFS_ADDR_CBC_CTRL 8'h77
`define CPFS_ADDR_FAULT_CLR 8'h78
`define CPFS_ADDR_XOR_SUM 8'h7D
`define CPFS_ADDR_CRC_SUM 8'h7E
`define CPFS_ADDR_BOOK_SEL 8'h7F

// Books and pages
`define CPFS_PAGE_ZERO 8'h00
`define CPFS_BOOK_ZERO 8'h00
`define CPFS_BOOK_XOR 8'h8C
`define CPFS_BOOK_BIQUAD 8'hAA

// Checksum
`define CPFS_CRC_POLY 8'h07
`define CPFS_SUM_RESET 8'h00

// Field positions and values
`define CPFS_HIZ_LSB 0
`define CPFS_HIZ_CODE 2'h2
`define CPFS_CBC_LSB 3
`define CPFS_CBC_OFF 2'h0
`define CPFS_DROP_EN_BIT 0
`define CPFS_DROP_HIZ_BIT 1
`define CPFS_DROP_LVL_RESET 8'h08
`define CPFS_CLR_BIT 0

// Fault status bit positions
`define CPFS_FLT_OC 0
`define CPFS_FLT_DC 1
`define CPFS_FLT_OT 2
`define CPFS_FLT_UV 3
`define CPFS_FLT_OV 4

// Reset values
`define CPFS_DEV_CTRL2_RESET 8'h02
`define CPFS_CBC_CTRL_RESET 8'h00
`define CPFS_ZERO8 8'h00

// Timing
`define CPFS_CLK_NS 10
`define CPFS_OC_RESP_NS 100
`define CPFS_OC_RESP_CYC (`CPFS_OC_RESP_NS / `CPFS_CLK_NS)
`define CPFS_MUTE_RAMP_CYC 8'h20

`endif

// ### cpfs_pkg.sv
package cpfs_pkg;

    typedef logic [7:0] cpfs_byte_t;

    // One register-port access from the serial front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic start;
        cpfs_byte_t data;
    } cpfs_req_s;

    // Analog-side detector levels
    typedef struct packed {
        logic oc;
        logic dc;
        logic ot;
        logic uv;
        logic ov;
    } cpfs_det_s;

    typedef enum logic [1:0] {
        CPFS_CLK_OK,
        CPFS_CLK_RAMP,
        CPFS_CLK_MUTED
    } cpfs_clk_e;

endpackage : cpfs_pkg

// ### cpfs_crc8.sv
`timescale 1ns/10ps
`include "cpfs_regs.svh"

// One CRC-8 step over a byte, registered
module cpfs_crc8
    import cpfs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control
    input wire logic step,
    input wire logic clear,
    input wire cpfs_byte_t data,
    // Result
    output cpfs_byte_t crc
);
    cpfs_byte_t crc_reg;
    cpfs_byte_t crc_next;
    cpfs_byte_t acc;

    always_comb begin
        acc = crc_reg ^ data;
        // Msb first, no final inversion
        for (int i = 0; i < 8; i++) begin
            acc = acc[7] ? ((acc << 1) ^ `CPFS_CRC_POLY) : (acc << 1);
        end
        crc_next = crc_reg;
        if (clear) begin
            crc_next = `CPFS_SUM_RESET;
        end else if (step) begin
            crc_next = acc;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            crc_reg <= `CPFS_SUM_RESET;
        end else begin
            crc_reg <= crc_next;
        end
    end

    assign crc = crc_reg;

endmodule : cpfs_crc8

// ### cpfs_supervisor.sv
`timescale 1ns/10ps
`include "cpfs_regs.svh"

module cpfs_supervisor
    import cpfs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port from the serial front end
    input wire cpfs_req_s req,
    output cpfs_byte_t rd_data,
    output logic wr_ack,
    // Power-down pin, high enables
    input wire logic power_down_n,
    // Detectors
    input wire cpfs_det_s det,
    input wire logic dc_timed_out,
    input wire logic cur_over_limit,
    input wire logic supply_below_drop,
    input wire logic clk_error,
    // Outputs
    output logic fault_out_n,
    output logic out_hiz,
    output logic pwm_chop,
    output logic supply_drop_flag,
    output logic hard_mute,
    output logic atten_ramp,
    output logic use_int_osc,
    output cpfs_byte_t cur_addr,
    output cpfs_byte_t cur_book,
    output cpfs_byte_t cur_page
);
    cpfs_byte_t addr_reg, addr_next;
    cpfs_byte_t book_reg, book_next;
    cpfs_byte_t page_reg, page_next;
    logic addr_pend_reg, addr_pend_next;
    cpfs_byte_t xor_reg, xor_next;
    cpfs_byte_t dev2_reg, dev2_next;
    cpfs_byte_t drop1_reg, drop1_next;
    cpfs_byte_t drop2_reg, drop2_next;
    cpfs_byte_t cbc_reg, cbc_next;
    logic [4:0] flt_reg, flt_next;
    cpfs_clk_e clk_st_reg, clk_st_next;
    cpfs_byte_t ramp_reg, ramp_next;
    cpfs_byte_t rd_reg, rd_next;
    logic ack_reg, ack_next;
    logic fault_n_reg, fault_n_next;
    logic hiz_reg, hiz_next;
    logic chop_reg, chop_next;
    logic drop_reg, drop_next;
    cpfs_byte_t crc_val;
    logic [2:0] clk_out_reg, clk_out_next;
    logic data_wr, sel_wr, crc_step, crc_clear, flt_clr, on_p0, drop_hiz, any_flt;

    cpfs_crc8 u_crc (
        .clk(clk),
        .reset(reset),
        .step(crc_step),
        .clear(crc_clear),
        .data(req.data),
        .crc(crc_val)
    );

    // Write decode; first byte after start is the subaddress
    always_comb begin
        data_wr = req.wr && !req.start && addr_pend_reg;
        on_p0 = (page_reg == `CPFS_PAGE_ZERO);
        sel_wr = data_wr && ((addr_reg == `CPFS_ADDR_PAGE_SEL)
            || (on_p0 && addr_reg == `CPFS_ADDR_BOOK_SEL));
        // Reset write of 0x00 to the CRC slot wins over folding it
        crc_clear = data_wr && on_p0 && addr_reg == `CPFS_ADDR_CRC_SUM
            && req.data == `CPFS_SUM_RESET;
        crc_step = data_wr && !sel_wr && !crc_clear;
        flt_clr = data_wr && on_p0 && addr_reg == `CPFS_ADDR_FAULT_CLR
            && req.data[`CPFS_CLR_BIT];
    end

    // Addressing, selects, checksums and config
    always_comb begin
        addr_next = addr_reg;
        addr_pend_next = addr_pend_reg;
        book_next = book_reg;
        page_next = page_reg;
        xor_next = xor_reg;
        dev2_next = dev2_reg;
        drop1_next = drop1_reg;
        drop2_next = drop2_reg;
        cbc_next = cbc_reg;
        rd_next = rd_reg;
        ack_next = 1'b0;
        if (req.wr && req.start) begin
            addr_next = req.data;
            addr_pend_next = 1'b1;
            ack_next = 1'b1;
        end else if (data_wr) begin
            ack_next = 1'b1;
            addr_next = addr_reg + 8'h01;
            if (addr_reg == `CPFS_ADDR_PAGE_SEL) begin
                page_next = req.data;
            end else if (on_p0 && addr_reg == `CPFS_ADDR_BOOK_SEL) begin
                book_next = req.data;
            end
            if (book_reg == `CPFS_BOOK_XOR && !on_p0 && !sel_wr) begin
                xor_next = xor_reg ^ req.data;
            end else if (book_reg == `CPFS_BOOK_XOR && on_p0
                && addr_reg == `CPFS_ADDR_XOR_SUM
                && req.data == `CPFS_SUM_RESET) begin
                xor_next = `CPFS_SUM_RESET;
            end
            if (on_p0) begin
                case (addr_reg)
                    `CPFS_ADDR_DEV_CTRL2: dev2_next = req.data;
                    `CPFS_ADDR_DROP_CTRL1: drop1_next = req.data;
                    `CPFS_ADDR_DROP_CTRL2: drop2_next = req.data;
                    `CPFS_ADDR_CBC_CTRL: cbc_next = req.data;
                    default: ;
                endcase
            end
        end else if (req.rd) begin
            addr_next = addr_reg + 8'h01;
            rd_next = `CPFS_ZERO8;
            if (addr_reg == `CPFS_ADDR_PAGE_SEL) begin
                rd_next = page_reg;
            end else if (on_p0) begin
                case (addr_reg)
                    `CPFS_ADDR_BOOK_SEL: rd_next = book_reg;
                    `CPFS_ADDR_CRC_SUM: rd_next = crc_val;
                    `CPFS_ADDR_XOR_SUM: rd_next =
                        (book_reg == `CPFS_BOOK_XOR) ? xor_reg : `CPFS_ZERO8;
                    `CPFS_ADDR_DEV_CTRL2: rd_next = dev2_reg;
                    `CPFS_ADDR_DROP_CTRL1: rd_next = drop1_reg;
                    `CPFS_ADDR_DROP_CTRL2: rd_next = drop2_reg;
                    `CPFS_ADDR_CBC_CTRL: rd_next = cbc_reg;
                    `CPFS_ADDR_FAULT_STAT: rd_next = {3'h0, flt_reg};
                    `CPFS_ADDR_CLK_STAT: rd_next =
                        {7'h00, clk_st_reg != CPFS_CLK_OK};
                    default: rd_next = `CPFS_ZERO8;
                endcase
            end
        end
    end

    // Faults; latched ones reset only when the cause has gone
    always_comb begin
        flt_next = flt_reg;
        if (flt_clr) begin
            flt_next[`CPFS_FLT_OC] = 1'b0;
            flt_next[`CPFS_FLT_DC] = 1'b0;
            flt_next[`CPFS_FLT_OT] = 1'b0;
        end
        // Set wins over clear, so a still-present cause re-latches
        if (det.oc) flt_next[`CPFS_FLT_OC] = 1'b1;
        if (det.dc && dc_timed_out) flt_next[`CPFS_FLT_DC] = 1'b1;
        if (det.ot) flt_next[`CPFS_FLT_OT] = 1'b1;
        flt_next[`CPFS_FLT_UV] = det.uv;
        flt_next[`CPFS_FLT_OV] = det.ov;
        drop_hiz = drop1_reg[`CPFS_DROP_EN_BIT] && drop1_reg[`CPFS_DROP_HIZ_BIT]
            && supply_below_drop;
        any_flt = |flt_next;
        // Level taken straight from detector so shutdown lands next edge
        fault_n_next = !any_flt;
        hiz_next = any_flt || !power_down_n || drop_hiz
            || dev2_reg[`CPFS_HIZ_LSB +: 2] == `CPFS_HIZ_CODE;
        chop_next = cur_over_limit
            && cbc_reg[`CPFS_CBC_LSB +: 2] != `CPFS_CBC_OFF;
        drop_next = !(drop1_reg[`CPFS_DROP_EN_BIT] && supply_below_drop);
    end

    // Clock loss: ramp down then mute, recover on return
    always_comb begin
        clk_st_next = clk_st_reg;
        ramp_next = ramp_reg;
        case (clk_st_reg)
            CPFS_CLK_OK: begin
                if (clk_error) begin
                    clk_st_next = CPFS_CLK_RAMP;
                    ramp_next = `CPFS_MUTE_RAMP_CYC;
                end
            end
            CPFS_CLK_RAMP: begin
                if (!clk_error) begin
                    clk_st_next = CPFS_CLK_OK;
                end else if (ramp_reg == `CPFS_ZERO8) begin
                    clk_st_next = CPFS_CLK_MUTED;
                end else begin
                    ramp_next = ramp_reg - 8'h01;
                end
            end
            CPFS_CLK_MUTED: begin
                if (!clk_error) begin
                    clk_st_next = CPFS_CLK_OK;
                end
            end
            default: clk_st_next = CPFS_CLK_OK;
        endcase
        clk_out_next = {clk_st_next != CPFS_CLK_OK, clk_st_next == CPFS_CLK_RAMP,
            clk_st_next == CPFS_CLK_MUTED};
    end

    always_ff @(posedge clk) begin
        if (reset || !power_down_n) begin
            addr_reg <= `CPFS_ZERO8;
            addr_pend_reg <= 1'b0;
            book_reg <= `CPFS_BOOK_ZERO;
            page_reg <= `CPFS_PAGE_ZERO;
            xor_reg <= `CPFS_SUM_RESET;
            dev2_reg <= `CPFS_DEV_CTRL2_RESET;
            drop1_reg <= `CPFS_ZERO8;
            drop2_reg <= `CPFS_DROP_LVL_RESET;
            cbc_reg <= `CPFS_CBC_CTRL_RESET;
            flt_reg <= 5'h00;
            clk_st_reg <= CPFS_CLK_OK;
            ramp_reg <= `CPFS_ZERO8;
            clk_out_reg <= '0;
            rd_reg <= `CPFS_ZERO8;
            ack_reg <= 1'b0;
            fault_n_reg <= 1'b1;
            hiz_reg <= 1'b1;
            chop_reg <= 1'b0;
            drop_reg <= 1'b1;
        end else begin
            addr_reg <= addr_next;
            addr_pend_reg <= addr_pend_next;
            book_reg <= book_next;
            page_reg <= page_next;
            xor_reg <= xor_next;
            dev2_reg <= dev2_next;
            drop1_reg <= drop1_next;
            drop2_reg <= drop2_next;
            cbc_reg <= cbc_next;
            flt_reg <= flt_next;
            clk_st_reg <= clk_st_next;
            ramp_reg <= ramp_next;
            clk_out_reg <= clk_out_next;
            rd_reg <= rd_next;
            ack_reg <= ack_next;
            fault_n_reg <= fault_n_next;
            hiz_reg <= hiz_next;
            chop_reg <= chop_next;
            drop_reg <= drop_next;
        end
    end

    assign rd_data = rd_reg;
    assign wr_ack = ack_reg;
    assign fault_out_n = fault_n_reg;
    assign out_hiz = hiz_reg;
    assign pwm_chop = chop_reg;
    assign supply_drop_flag = drop_reg;
    assign use_int_osc = clk_out_reg[2];
    assign atten_ramp = clk_out_reg[1];
    assign hard_mute = clk_out_reg[0];
    assign cur_addr = addr_reg;
    assign cur_book = book_reg;
    assign cur_page = page_reg;
    // Assertions
    property p_oc_shut;
        @(posedge clk) disable iff (reset || !power_down_n)
        det.oc |=> (!fault_out_n && out_hiz);
    endproperty
    a_oc_shut: assert property (p_oc_shut) else $error("overcurrent not shut");
    property p_oc_latch;
        @(posedge clk) disable iff (reset || !power_down_n)
        (flt_reg[`CPFS_FLT_OC] && !flt_clr) |=> flt_reg[`CPFS_FLT_OC];
    endproperty
    a_oc_latch: assert property (p_oc_latch) else $error("oc fault dropped");
    property p_ot_latch;
        @(posedge clk) disable iff (reset || !power_down_n)
        (flt_reg[`CPFS_FLT_OT] && !flt_clr) |=> flt_reg[`CPFS_FLT_OT];
    endproperty
    a_ot_latch: assert property (p_ot_latch) else $error("ot fault dropped");
    property p_clr_recheck;
        @(posedge clk) disable iff (reset || !power_down_n)
        (flt_clr && det.dc && dc_timed_out) |=> flt_reg[`CPFS_FLT_DC];
    endproperty
    a_clr_recheck: assert property (p_clr_recheck) else $error("dc fault lost");
    property p_uv_self;
        @(posedge clk) disable iff (reset || !power_down_n)
        !det.uv |=> !flt_reg[`CPFS_FLT_UV];
    endproperty
    a_uv_self: assert property (p_uv_self) else $error("uv not self clearing");
    property p_read_keeps;
        @(posedge clk) disable iff (reset || !power_down_n)
        (req.rd && !req.wr) |=> ($stable(crc_val) && $stable(xor_reg));
    endproperty
    a_read_keeps: assert property (p_read_keeps) else $error("read moved sum");
    property p_addr_inc;
        @(posedge clk) disable iff (reset || !power_down_n)
        (data_wr || (req.rd && !req.wr)) |=> (cur_addr == $past(cur_addr) + 8'h01);
    endproperty
    a_addr_inc: assert property (p_addr_inc) else $error("subaddr no step");
    property p_book_sel;
        @(posedge clk) disable iff (reset || !power_down_n)
        (data_wr && on_p0 && addr_reg == `CPFS_ADDR_BOOK_SEL) |=>
            (cur_book == $past(req.data));
    endproperty
    a_book_sel: assert property (p_book_sel) else $error("book not set");
    property p_sel_no_crc;
        @(posedge clk) disable iff (reset || !power_down_n)
        sel_wr |=> $stable(crc_val);
    endproperty
    a_sel_no_crc: assert property (p_sel_no_crc) else $error("select hit crc");
    sequence s_clk_lost;
        clk_error ##1 clk_error;
    endsequence
    property p_clk_ramp;
        @(posedge clk) disable iff (reset || !power_down_n)
        (clk_st_reg == CPFS_CLK_OK) ##0 s_clk_lost |-> atten_ramp;
    endproperty
    a_clk_ramp: assert property (p_clk_ramp) else $error("no ramp on clk loss");

endmodule : cpfs_supervisor

// ### cpfs_host_model.sv
`timescale 1ns/10ps

// Host controller driving the register port and the power-down pin
module cpfs_host_model
    import cpfs_pkg::*;
(
    // Clock
    input wire logic clk,
    // Register port
    output cpfs_req_s req,
    input wire cpfs_byte_t rd_data,
    input wire logic wr_ack,
    // Power-down pin and acknowledge tally
    output logic power_down_n,
    output int unsigned n_acks
);
    cpfs_byte_t rbuf [8];

    initial begin
        req = '0;
        power_down_n = 1'b0;
        n_acks = 0;
    end

    always @(posedge clk) begin
        if (wr_ack === 1'b1) begin
            n_acks <= n_acks + 1;
        end
    end

    // Released bus shows no stale byte
    function automatic cpfs_req_s idle();
        return '{wr: 1'b0, rd: 1'b0, start: 1'b0, data: ~req.data};
    endfunction : idle

    task automatic send(input logic st, input cpfs_byte_t d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, start: st, data: d};
    endtask : send

    task automatic write(input cpfs_byte_t a, input cpfs_byte_t q[$]);
        send(1'b1, a);
        foreach (q[i]) send(1'b0, q[i]);
        @(posedge clk);
        req <= idle();
        // Return past the edge so callers see the last byte's effect
        #1;
    endtask : write

    // Last byte ends the read: bus released, no further byte asked
    task automatic read(input cpfs_byte_t a, input int n);
        send(1'b1, a);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, start: 1'b0, data: ~a};
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            if (i == n - 1) req <= idle();
            #1 rbuf[i] = rd_data;
        end
    endtask : read

    task automatic set_book(input cpfs_byte_t b);
        write(`CPFS_ADDR_PAGE_SEL, '{8'h00});
        write(`CPFS_ADDR_BOOK_SEL, '{b});
    endtask : set_book

    // 100 us at 100 MHz before the pin rises
    task automatic power_up();
        @(posedge clk);
        power_down_n <= 1'b0;
        repeat (10000) @(posedge clk);
        power_down_n <= 1'b1;
    endtask : power_up

    task automatic power_down();
        write(`CPFS_ADDR_DEV_CTRL2, '{8'h02});
        @(posedge clk);
        power_down_n <= 1'b0;
    endtask : power_down
endmodule : cpfs_host_model

// ### tb_top.sv
`timescale 1ns/10ps
`include "cpfs_regs.svh"

`define CHECK_EQ(act, exp) begin n_checks++; if ((act) !== (exp)) begin mismatches++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, act, exp); end end

module tb_top
    import cpfs_pkg::*;
;
    logic clk, reset, dc_timed_out, cur_over_limit, supply_below_drop, clk_error;
    logic power_down_n, wr_ack, fault_out_n, out_hiz, pwm_chop, supply_drop_flag;
    logic hard_mute, atten_ramp, use_int_osc;
    cpfs_req_s req;
    cpfs_det_s det;
    cpfs_byte_t rd_data, cur_addr, cur_book, cur_page, crc, xsum;
    cpfs_byte_t q[$];
    int unsigned n_acks, acks0;
    int mismatches = 0;
    int n_checks = 0;
    int cnt;

    cpfs_supervisor i_cpfs_supervisor (.clk(clk), .reset(reset), .req(req),
        .rd_data(rd_data), .wr_ack(wr_ack), .power_down_n(power_down_n), .det(det),
        .dc_timed_out(dc_timed_out), .cur_over_limit(cur_over_limit),
        .supply_below_drop(supply_below_drop), .clk_error(clk_error),
        .fault_out_n(fault_out_n), .out_hiz(out_hiz), .pwm_chop(pwm_chop),
        .supply_drop_flag(supply_drop_flag), .hard_mute(hard_mute), .atten_ramp(atten_ramp),
        .use_int_osc(use_int_osc), .cur_addr(cur_addr), .cur_book(cur_book),
        .cur_page(cur_page));

    cpfs_host_model i_cpfs_host_model (.clk(clk), .req(req), .rd_data(rd_data),
        .wr_ack(wr_ack), .power_down_n(power_down_n), .n_acks(n_acks));

    // Msb first, no final inversion
    function automatic cpfs_byte_t crc_step(input cpfs_byte_t c, input cpfs_byte_t d);
        c = c ^ d;
        repeat (8) c = c[7] ? ((c << 1) ^ `CPFS_CRC_POLY) : (c << 1);
        return c;
    endfunction : crc_step

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        results();
    end

    initial begin
        void'($urandom(32'h1BAF68C5));
        reset = 1'b1;
        det = '0;
        dc_timed_out = 1'b0;
        cur_over_limit = 1'b0;
        supply_below_drop = 1'b0;
        clk_error = 1'b0;
        fork
            i_cpfs_host_model.power_up();
        join_none
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        wait (power_down_n === 1'b1);
        tick(2);
        `CHECK_EQ(fault_out_n, 1'b1)
        i_cpfs_host_model.read(8'h03, 3);
        `CHECK_EQ(i_cpfs_host_model.rbuf[0], `CPFS_DEV_CTRL2_RESET)
        `CHECK_EQ(i_cpfs_host_model.rbuf[2], `CPFS_DROP_LVL_RESET)
        `CHECK_EQ(cur_addr, 8'h06)
        // Checksums over a random burst on page one of the XOR book
        i_cpfs_host_model.set_book(`CPFS_BOOK_XOR);
        `CHECK_EQ(cur_book, `CPFS_BOOK_XOR)
        i_cpfs_host_model.write(`CPFS_ADDR_XOR_SUM, '{8'h00});
        i_cpfs_host_model.write(`CPFS_ADDR_CRC_SUM, '{8'h00});
        i_cpfs_host_model.write(`CPFS_ADDR_PAGE_SEL, '{8'h01});
        tick(2);
        `CHECK_EQ(cur_page, 8'h01)
        crc = 8'h00;
        xsum = 8'h00;
        repeat (5) begin
            q.push_back(8'($urandom));
            crc = crc_step(crc, q[$]);
            xsum = xsum ^ q[$];
        end
        acks0 = n_acks;
        i_cpfs_host_model.write(8'h20, q);
        tick(2);
        `CHECK_EQ(cur_addr, 8'h25)
        `CHECK_EQ(32'(n_acks - acks0), 32'd6)
        i_cpfs_host_model.write(`CPFS_ADDR_PAGE_SEL, '{8'h02});
        i_cpfs_host_model.write(`CPFS_ADDR_PAGE_SEL, '{8'h00});
        i_cpfs_host_model.read(`CPFS_ADDR_XOR_SUM, 2);
        `CHECK_EQ(i_cpfs_host_model.rbuf[0], xsum)
        `CHECK_EQ(i_cpfs_host_model.rbuf[1], crc)
        i_cpfs_host_model.read(`CPFS_ADDR_CRC_SUM, 1);
        `CHECK_EQ(i_cpfs_host_model.rbuf[0], crc)
        i_cpfs_host_model.write(`CPFS_ADDR_CRC_SUM, '{8'h00});
        i_cpfs_host_model.read(`CPFS_ADDR_CRC_SUM, 1);
        `CHECK_EQ(i_cpfs_host_model.rbuf[0], `CPFS_SUM_RESET)
        // Five biquad coefficients, ascending, folded into the CRC in order
        i_cpfs_host_model.set_book(`CPFS_BOOK_BIQUAD);
        i_cpfs_host_model.write(`CPFS_ADDR_PAGE_SEL, '{8'h01});
        q.delete();
        crc = `CPFS_SUM_RESET;
        repeat (5) begin
            q.push_back(8'($urandom));
            crc = crc_step(crc, q[$]);
        end
        i_cpfs_host_model.write(8'h08, q);
        `CHECK_EQ(cur_addr, 8'h0D)
        i_cpfs_host_model.write(`CPFS_ADDR_PAGE_SEL, '{8'h00});
        i_cpfs_host_model.read(`CPFS_ADDR_CRC_SUM, 1);
        `CHECK_EQ(i_cpfs_host_model.rbuf[0], crc)
        i_cpfs_host_model.set_book(`CPFS_BOOK_ZERO);
        `CHECK_EQ(cur_book, `CPFS_BOOK_ZERO)
        i_cpfs_host_model.write(`CPFS_ADDR_DEV_CTRL2, '{8'h03});
        tick(3);
        `CHECK_EQ(out_hiz, 1'b0)
        // Latched faults first, then the self-clearing supply faults
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            det <= cpfs_det_s'(5'h10 >> k);
            dc_timed_out <= (k == 1);
            tick(2);
            `CHECK_EQ(fault_out_n, 1'b0)
            `CHECK_EQ(out_hiz, 1'b1)
            i_cpfs_host_model.read(`CPFS_ADDR_FAULT_STAT, 1);
            `CHECK_EQ(i_cpfs_host_model.rbuf[0][k], 1'b1)
            i_cpfs_host_model.write(`CPFS_ADDR_FAULT_CLR, '{8'h01});
            tick(2);
            `CHECK_EQ(fault_out_n, 1'b0)
            @(posedge clk);
            det <= '0;
            dc_timed_out <= 1'b0;
            tick(3);
            if (k < 3) begin
                `CHECK_EQ(fault_out_n, 1'b0)
                i_cpfs_host_model.write(`CPFS_ADDR_FAULT_CLR, '{8'h01});
                tick(3);
            end
            `CHECK_EQ(fault_out_n, 1'b1)
            `CHECK_EQ(out_hiz, 1'b0)
        end
        i_cpfs_host_model.write(`CPFS_ADDR_CBC_CTRL, '{8'($urandom_range(3, 1)) << 3});
        @(posedge clk);
        cur_over_limit <= 1'b1;
        tick(2);
        `CHECK_EQ(pwm_chop, 1'b1)
        i_cpfs_host_model.write(`CPFS_ADDR_CBC_CTRL, '{8'h00});
        tick(2);
        `CHECK_EQ(pwm_chop, 1'b0)
        i_cpfs_host_model.write(`CPFS_ADDR_DROP_CTRL1, '{8'h03});
        @(posedge clk);
        cur_over_limit <= 1'b0;
        supply_below_drop <= 1'b1;
        tick(2);
        `CHECK_EQ(supply_drop_flag, 1'b0)
        `CHECK_EQ(out_hiz, 1'b1)
        @(posedge clk);
        supply_below_drop <= 1'b0;
        tick(2);
        `CHECK_EQ(supply_drop_flag, 1'b1)
        @(posedge clk);
        clk_error <= 1'b1;
        tick(2);
        `CHECK_EQ({atten_ramp, use_int_osc}, 2'b11)
        for (cnt = 2; cnt < 60 && hard_mute !== 1'b1; cnt++) tick(1);
        `CHECK_EQ(1'(cnt >= 30 && cnt <= 36), 1'b1)
        @(posedge clk);
        clk_error <= 1'b0;
        tick(3);
        `CHECK_EQ({hard_mute, use_int_osc}, 2'b00)
        i_cpfs_host_model.power_down();
        tick(3);
        `CHECK_EQ(out_hiz, 1'b1)
        i_cpfs_host_model.power_up();
        i_cpfs_host_model.read(`CPFS_ADDR_DROP_CTRL1, 2);
        `CHECK_EQ(i_cpfs_host_model.rbuf[0], `CPFS_ZERO8)
        `CHECK_EQ(i_cpfs_host_model.rbuf[1], `CPFS_DROP_LVL_RESET)
        results();
    end
endmodule : tb_top
